/* File: brad_defines.vh */
// Address map, codes and timing counts for the boot remap address decoder.
`ifndef BRAD_DEFINES_VH
`define BRAD_DEFINES_VH
// ----------------------------------------------------------------------
// Region bases and sizes
// ----------------------------------------------------------------------
`define BRAD_BOOT_BASE 32'h0000_0000
`define BRAD_FLASH_BASE 32'h0800_0000
`define BRAD_SYS_BASE 32'h1FFF_F000
`define BRAD_SYS_SIZE 32'h0000_0800
`define BRAD_OPT_BASE 32'h1FFF_F800
`define BRAD_OPT_SIZE 32'h0000_0010
`define BRAD_SRAM_BASE 32'h2000_0000
`define BRAD_SRAM_BB 32'h2200_0000
`define BRAD_PER_BASE 32'h4000_0000
`define BRAD_PER_BB 32'h4200_0000
`define BRAD_BB_SIZE 32'h0200_0000
`define BRAD_PER_END 32'h6000_0000
`define BRAD_EMMC_END 32'hA000_0000
`define BRAD_PAGE_BYTES 32'h0000_0400
`define BRAD_BB_SCALE 32'h0000_0020
// ----------------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------------
`define BRAD_SZ_BYTE 2'h0
`define BRAD_SZ_HALF 2'h1
`define BRAD_SZ_WORD 2'h2
// ----------------------------------------------------------------------
// Decoded targets
// ----------------------------------------------------------------------
`define BRAD_T_ERR 3'h0
`define BRAD_T_SRAM 3'h1
`define BRAD_T_SRAMBB 3'h2
`define BRAD_T_FLASH 3'h3
`define BRAD_T_EMMC 3'h4
`define BRAD_T_APB 3'h5
`define BRAD_T_APBBB 3'h6
// ----------------------------------------------------------------------
// Downstream slave select codes
// ----------------------------------------------------------------------
`define BRAD_SEL_FLASH 2'h0
`define BRAD_SEL_EMMC 2'h1
`define BRAD_SEL_APB 2'h2
// ----------------------------------------------------------------------
// Boot modes and boot pin settling
// ----------------------------------------------------------------------
`define BRAD_MODE_FLASH 2'h0
`define BRAD_MODE_SYS 2'h1
`define BRAD_MODE_SRAM 2'h2
`define BRAD_BOOT_WAIT 2'h3
`endif

/* File: brad_decoder.v */
// Boot remap address decoder with internal SRAM and bit-band alias handling.
`timescale 1ns/1ps
`include "brad_defines.vh"
module brad_decoder #(
  parameter FLASH_PAGES = 128,
  parameter SRAM_AW = 12
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // Boot pins and power state
  input wire i_boot_select_primary_pin,
  input wire i_boot_select_secondary_pin,
  input wire i_standby_exit,
  output wire [1:0] o_boot_mode,
  output wire o_boot_valid,
  // Masters: index 0 data-code, 1 system, 2 DMA
  input wire [2:0] i_m_valid,
  input wire [95:0] i_m_addr,
  input wire [2:0] i_m_write,
  input wire [5:0] i_m_size,
  input wire [95:0] i_m_wdata,
  output wire [2:0] o_m_ready,
  output wire [2:0] o_m_err,
  output wire [31:0] o_m_rdata,
  // Shared downstream port to flash, external memory and bridge
  output wire o_slv_req,
  output wire [1:0] o_slv_sel,
  output wire [31:0] o_slv_addr,
  output wire o_slv_write,
  output wire [1:0] o_slv_size,
  output wire [31:0] o_slv_wdata,
  input wire i_slv_ready,
  input wire i_slv_err,
  input wire [31:0] i_slv_rdata
);

  // --------------------------------------------------------------------
  // Sizes and states
  // --------------------------------------------------------------------
  localparam [31:0] FLASH_BYTES = FLASH_PAGES * `BRAD_PAGE_BYTES;
  localparam [31:0] SRAM_BYTES = 32'h0000_0004 << SRAM_AW;
  localparam [31:0] SRAM_BB_BYTES = SRAM_BYTES * `BRAD_BB_SCALE;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SRAM = 3'h1;
  localparam [2:0] S_EXT = 3'h2;
  localparam [2:0] S_BBWR = 3'h3;
  localparam [2:0] S_RESP = 3'h4;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Returns the target code in the top bits and the physical or offset
  // address in the low 32 bits.
  function [34:0] decode;
    input [31:0] a;
    input [1:0] m;
    begin
      decode = {`BRAD_T_ERR, a};
      if (m == `BRAD_MODE_FLASH && a < FLASH_BYTES)
        decode = {`BRAD_T_FLASH, `BRAD_FLASH_BASE + a};
      else if (m == `BRAD_MODE_SYS && a < `BRAD_SYS_SIZE)
        decode = {`BRAD_T_FLASH, `BRAD_SYS_BASE + a};
      else if (a >= `BRAD_FLASH_BASE && a < `BRAD_FLASH_BASE + FLASH_BYTES)
        decode = {`BRAD_T_FLASH, a};
      else if (a >= `BRAD_SYS_BASE && a < `BRAD_OPT_BASE + `BRAD_OPT_SIZE)
        decode = {`BRAD_T_FLASH, a};
      else if (a >= `BRAD_SRAM_BASE && a < `BRAD_SRAM_BASE + SRAM_BYTES)
        decode = {`BRAD_T_SRAM, a - `BRAD_SRAM_BASE};
      else if (a >= `BRAD_SRAM_BB && a < `BRAD_SRAM_BB + SRAM_BB_BYTES)
        decode = {`BRAD_T_SRAMBB, a - `BRAD_SRAM_BB};
      else if (a >= `BRAD_PER_BB && a < `BRAD_PER_BB + `BRAD_BB_SIZE)
        decode = {`BRAD_T_APBBB, a - `BRAD_PER_BB};
      else if (a >= `BRAD_PER_BASE && a < `BRAD_PER_END)
        decode = {`BRAD_T_APB, a};
      else if (a >= `BRAD_PER_END && a < `BRAD_EMMC_END)
        decode = {`BRAD_T_EMMC, a};
    end
  endfunction

  // Halfwords and words must be naturally aligned.
  function aligned;
    input [1:0] sz;
    input [1:0] a;
    begin
      aligned = (sz == `BRAD_SZ_BYTE) || (sz == `BRAD_SZ_HALF && !a[0]) ||
        (sz == `BRAD_SZ_WORD && a == 2'h0);
    end
  endfunction

  function [3:0] lanes;
    input [1:0] sz;
    input [1:0] a;
    begin
      case (sz)
        `BRAD_SZ_BYTE: lanes = 4'h1 << a;
        `BRAD_SZ_HALF: lanes = a[1] ? 4'hC : 4'h3;
        default: lanes = 4'hF;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Boot pin capture
  // --------------------------------------------------------------------
  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg [1:0] wait_q;
  reg [1:0] mode_q;

  // The pins are only trusted once both sync stages hold post-reset
  // samples, so the latch waits out the synchroniser depth.
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      wait_q <= `BRAD_BOOT_WAIT;
      mode_q <= `BRAD_MODE_FLASH;
    end
    else
    begin
      pin_s1_q <= {i_boot_select_secondary_pin, i_boot_select_primary_pin};
      pin_s2_q <= pin_s1_q;
      if (i_standby_exit)
        wait_q <= `BRAD_BOOT_WAIT;
      else if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1 && !i_standby_exit)
      begin
        if (!pin_s2_q[0])
          mode_q <= `BRAD_MODE_FLASH;
        else if (!pin_s2_q[1])
          mode_q <= `BRAD_MODE_SYS;
        else
          mode_q <= `BRAD_MODE_SRAM;
      end
    end
  end

  assign o_boot_mode = mode_q;
  assign o_boot_valid = (wait_q == 2'h0);

  // --------------------------------------------------------------------
  // Arbitration and request capture
  // --------------------------------------------------------------------
  reg [2:0] st_q;
  reg [1:0] gnt_q;
  reg [2:0] tgt_q;
  reg [31:0] off_q;
  reg [31:0] xaddr_q;
  reg wr_q;
  reg [1:0] size_q;
  reg [31:0] wdata_q;
  reg [31:0] rdata_q;
  reg err_q;
  reg [31:0] mem [0:(1 << SRAM_AW) - 1];

  reg [1:0] pick;
  reg [31:0] req_addr;
  reg [34:0] dec;
  always @*
  begin
    // The DMA wins over the system bus, which wins over data-code.
    if (i_m_valid[2])
      pick = 2'h2;
    else if (i_m_valid[1])
      pick = 2'h1;
    else
      pick = 2'h0;
    req_addr = i_m_addr[32 * pick +: 32];
    dec = decode(req_addr, mode_q);
  end

  wire [SRAM_AW-1:0] sram_idx = off_q[SRAM_AW+1:2];
  wire [SRAM_AW-1:0] sbb_idx = off_q[SRAM_AW+6:7];
  wire [4:0] bb_bit = off_q[6:2];
  wire [3:0] be = lanes(size_q, off_q[1:0]);
  wire is_bb = (tgt_q == `BRAD_T_APBBB);
  integer i;

  // --------------------------------------------------------------------
  // Transfer engine
  // --------------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      st_q <= S_IDLE;
      gnt_q <= 2'h0;
      tgt_q <= `BRAD_T_ERR;
      off_q <= 32'h0000_0000;
      xaddr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      size_q <= `BRAD_SZ_BYTE;
      wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          if (o_boot_valid && i_m_valid != 3'h0)
          begin
            gnt_q <= pick;
            tgt_q <= dec[34:32];
            off_q <= dec[31:0];
            wr_q <= i_m_write[pick];
            size_q <= i_m_size[2 * pick +: 2];
            wdata_q <= i_m_wdata[32 * pick +: 32];
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            if (dec[34:32] == `BRAD_T_APBBB)
              xaddr_q <= `BRAD_PER_BASE + {12'h000, dec[24:7], 2'b00};
            else
              xaddr_q <= dec[31:0];
            if (dec[34:32] == `BRAD_T_ERR)
            begin
              err_q <= 1'b1;
              st_q <= S_RESP;
            end
            else if (dec[34:32] == `BRAD_T_SRAM || dec[34:32] == `BRAD_T_SRAMBB)
              st_q <= S_SRAM;
            else
              st_q <= S_EXT;
          end
        end
        S_SRAM:
        begin
          st_q <= S_RESP;
          if (tgt_q == `BRAD_T_SRAMBB)
          begin
            // A single-cycle update keeps the bit change atomic.
            if (wr_q)
              mem[sbb_idx][bb_bit] <= wdata_q[0];
            rdata_q <= {31'h0000_0000, mem[sbb_idx][bb_bit]};
          end
          else if (!aligned(size_q, off_q[1:0]))
            err_q <= 1'b1;
          else
          begin
            rdata_q <= mem[sram_idx];
            if (wr_q)
            begin
              for (i = 0; i < 4; i = i + 1)
                if (be[i])
                  mem[sram_idx][8 * i +: 8] <= wdata_q[8 * i +: 8];
            end
          end
        end
        S_EXT:
        begin
          if (i_slv_ready)
          begin
            if (i_slv_err)
            begin
              err_q <= 1'b1;
              st_q <= S_RESP;
            end
            else if (is_bb && wr_q)
            begin
              // Bus is held by this engine, so no master slips in between.
              wdata_q <= wdata_q[0] ? (i_slv_rdata | (32'h0000_0001 << bb_bit)) :
                (i_slv_rdata & ~(32'h0000_0001 << bb_bit));
              st_q <= S_BBWR;
            end
            else
            begin
              if (is_bb)
                rdata_q <= {31'h0000_0000, i_slv_rdata[bb_bit]};
              else
                rdata_q <= i_slv_rdata;
              st_q <= S_RESP;
            end
          end
        end
        S_BBWR:
        begin
          if (i_slv_ready)
          begin
            err_q <= i_slv_err;
            st_q <= S_RESP;
          end
        end
        S_RESP:
          st_q <= S_IDLE;
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_m_ready = (st_q == S_RESP) ? (3'h1 << gnt_q) : 3'h0;
  assign o_m_err = (st_q == S_RESP && err_q) ? (3'h1 << gnt_q) : 3'h0;
  assign o_m_rdata = rdata_q;
  assign o_slv_req = (st_q == S_EXT) || (st_q == S_BBWR);
  assign o_slv_sel = (tgt_q == `BRAD_T_FLASH) ? `BRAD_SEL_FLASH :
    (tgt_q == `BRAD_T_EMMC) ? `BRAD_SEL_EMMC : `BRAD_SEL_APB;
  assign o_slv_addr = xaddr_q;
  assign o_slv_write = (st_q == S_BBWR) || (st_q == S_EXT && wr_q && !is_bb);
  assign o_slv_size = is_bb ? `BRAD_SZ_WORD : size_q;
  assign o_slv_wdata = wdata_q;

endmodule // brad_decoder

/* File: brad_decoder_monitor.sv */
// Port checker for the boot remap address decoder.
`timescale 1ns/1ps
`include "brad_defines.vh"
module brad_decoder_monitor (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // Observed ports
  input wire i_standby_exit,
  input wire [1:0] o_boot_mode,
  input wire o_boot_valid,
  input wire [2:0] o_m_ready,
  input wire [2:0] o_m_err,
  input wire o_slv_req,
  input wire [1:0] o_slv_sel,
  input wire [31:0] o_slv_addr,
  input wire o_slv_write,
  input wire [1:0] o_slv_size,
  input wire [31:0] o_slv_wdata,
  input wire i_slv_ready
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  AST_READY_ONEHOT: assert property ($onehot0(o_m_ready))
    else $error("two masters answered at once");
  AST_ERR_WITH_READY: assert property ((o_m_err & ~o_m_ready) == 3'h0)
    else $error("error flag without ready");
  AST_NO_GRANT: assert property (!o_boot_valid |-> !o_slv_req && o_m_ready == 3'h0)
    else $error("access served before boot latch");
  AST_SLV_STABLE: assert property (o_slv_req && !i_slv_ready |=> o_slv_req &&
    $stable(o_slv_addr) && $stable(o_slv_sel) && $stable(o_slv_write) &&
    $stable(o_slv_wdata))
    else $error("slave request changed while waiting");
  AST_SLV_DONE: assert property (o_slv_req && i_slv_ready && o_slv_write |=>
    o_m_ready != 3'h0)
    else $error("no answer after slave write");
  AST_MODE_HELD: assert property (o_boot_valid && !i_standby_exit |=>
    o_boot_valid && $stable(o_boot_mode))
    else $error("boot mode moved without standby exit");
  AST_STANDBY_DROP: assert property (i_standby_exit |=> !o_boot_valid)
    else $error("boot latch not restarted");
  AST_RELATCH: assert property ($fell(o_boot_valid) |-> ##[1:6] o_boot_valid)
    else $error("boot latch took too long");
  AST_PHYS: assert property (o_slv_req |-> o_slv_addr >= `BRAD_FLASH_BASE)
    else $error("boot space address not remapped");
  AST_EMMC_RANGE: assert property (o_slv_req && o_slv_sel == `BRAD_SEL_EMMC |->
    o_slv_addr >= `BRAD_PER_END && o_slv_addr < `BRAD_EMMC_END)
    else $error("external memory selected out of range");
  AST_SLV_SIZE: assert property (o_slv_req |-> o_slv_size <= `BRAD_SZ_WORD)
    else $error("illegal access size on slave port");
  C_ALIAS: cover property (o_slv_req && o_slv_write && o_slv_sel == `BRAD_SEL_APB);
  C_ERR: cover property (o_m_err != 3'h0);
  C_STANDBY: cover property (i_standby_exit);
endmodule // brad_decoder_monitor

bind brad_decoder brad_decoder_monitor i_mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_standby_exit(i_standby_exit), .o_boot_mode(o_boot_mode), .o_boot_valid(o_boot_valid),
  .o_m_ready(o_m_ready), .o_m_err(o_m_err), .o_slv_req(o_slv_req), .o_slv_sel(o_slv_sel),
  .o_slv_addr(o_slv_addr), .o_slv_write(o_slv_write), .o_slv_size(o_slv_size),
  .o_slv_wdata(o_slv_wdata),
  .i_slv_ready(i_slv_ready));

/* File: brad_slave_model.sv */
// Behavioural model of the flash, external memory and bridge slaves.
`timescale 1ns/1ps
module brad_slave_model (
  // Clock
  input wire i_clk_sys,
  // Slave port
  input wire i_req,
  input wire [1:0] i_sel,
  input wire [31:0] i_addr,
  input wire i_write,
  input wire [31:0] i_wdata,
  input wire [1:0] i_dly,
  output wire o_ready,
  output reg [31:0] o_rdata,
  output reg [31:0] o_last_addr
);
  reg [31:0] mem [0:63];
  reg [1:0] cnt_q;
  reg [31:0] hold_q;
  wire [5:0] idx = {i_sel, i_addr[5:2]};
  integer i;
  initial
  begin
    cnt_q = 2'h0;
    hold_q = 32'h0000_0000;
    for (i = 0; i < 64; i = i + 1)
      mem[i] = 32'hF000_0000 + i;
  end
  assign o_ready = i_req && (cnt_q == i_dly);
  // Outside a completion the data lines show no stale word.
  always @*
    o_rdata = o_ready ? mem[idx] : ~hold_q;
  always @(posedge i_clk_sys)
  begin
    cnt_q <= (i_req && !o_ready) ? cnt_q + 2'h1 : 2'h0;
    if (o_ready)
    begin
      hold_q <= mem[idx];
      o_last_addr <= i_addr;
      if (i_write)
        mem[idx] <= i_wdata;
    end
  end
endmodule // brad_slave_model

/* File: brad_decoder_tb.sv */
// Self-checking testbench for the boot remap address decoder.
`timescale 1ns/1ps
module brad_decoder_tb;
  typedef struct packed {logic [1:0] m; logic [31:0] a; logic w; logic [1:0] sz;
    logic [31:0] d; logic [31:0] e; logic ee; logic [1:0] dly;} brad_row_t;
  reg clk = 1'b0, rstn = 1'b0, p0 = 1'b0, p1 = 1'b0, sbx = 1'b0, serr = 1'b0, gerr;
  reg [2:0] mv = 3'h0, mw = 3'h0;
  reg [95:0] ma = 96'h0, md = 96'h0;
  reg [5:0] ms = 6'h00;
  reg [1:0] dly = 2'h0;
  reg [31:0] got;
  wire [1:0] mode, ssel, ssz;
  wire bv, sreq, swr, srdy;
  wire [2:0] rdy, err;
  wire [31:0] rd, saddr, swd, srd, last;
  integer fails = 0, num_checks = 0, cyc = 0, i;
  brad_row_t rows [0:19];
  brad_row_t r;
  brad_decoder #(.FLASH_PAGES(4), .SRAM_AW(6)) i_dut (.i_clk_sys(clk), .i_resetn(rstn),
    .i_boot_select_primary_pin(p0), .i_boot_select_secondary_pin(p1), .i_standby_exit(sbx),
    .o_boot_mode(mode), .o_boot_valid(bv), .i_m_valid(mv), .i_m_addr(ma), .i_m_write(mw),
    .i_m_size(ms), .i_m_wdata(md), .o_m_ready(rdy), .o_m_err(err), .o_m_rdata(rd),
    .o_slv_req(sreq), .o_slv_sel(ssel), .o_slv_addr(saddr), .o_slv_write(swr),
    .o_slv_size(ssz), .o_slv_wdata(swd), .i_slv_ready(srdy), .i_slv_err(serr),
    .i_slv_rdata(srd));
  brad_slave_model i_slv (.i_clk_sys(clk), .i_req(sreq), .i_sel(ssel), .i_addr(saddr),
    .i_write(swr), .i_wdata(swd), .i_dly(dly), .o_ready(srdy), .o_rdata(srd),
    .o_last_addr(last));
  initial
    forever #20 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task acc(input [1:0] m, input [31:0] a, input w, input [1:0] sz, input [31:0] d);
    integer n;
    begin
      ma[m*32 +: 32] = a;
      md[m*32 +: 32] = d;
      ms[m*2 +: 2] = sz;
      mw[m] = w;
      mv[m] = 1'b1;
      n = 0;
      @(posedge clk);
      while (rdy[m] !== 1'b1 && n < 40)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, rdy[m]}, 32'h1);
      got = rd;
      gerr = err[m];
      #1 mv[m] = 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  // The pins settle for a few cycles so the two-flop sampler sees them.
  task relatch(input a, input b);
    integer n;
    begin
      p0 = a;
      p1 = b;
      repeat (3) @(posedge clk);
      #1 sbx = 1'b1;
      @(posedge clk);
      #1 sbx = 1'b0;
      n = 0;
      while (bv !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk({31'h0, bv}, 32'h1);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows[0] = {2'h1, 32'h2000_0010, 1'b1, 2'h2, 32'h1234_5678, 32'h0, 1'b0, 2'h0};
    rows[1] = {2'h2, 32'h2000_0011, 1'b1, 2'h0, 32'hABAB_ABAB, 32'h0, 1'b0, 2'h0};
    rows[2] = {2'h0, 32'h2000_0012, 1'b1, 2'h1, 32'hCDCD_CDCD, 32'h0, 1'b0, 2'h0};
    rows[3] = {2'h1, 32'h2200_0200, 1'b1, 2'h2, 32'h0000_0001, 32'h0, 1'b0, 2'h0};
    rows[4] = {2'h0, 32'h2000_0010, 1'b0, 2'h2, 32'h0, 32'hCDCD_AB79, 1'b0, 2'h0};
    rows[5] = {2'h2, 32'h2200_022C, 1'b0, 2'h2, 32'h0, 32'h0000_0001, 1'b0, 2'h0};
    rows[6] = {2'h1, 32'h2000_0002, 1'b1, 2'h2, 32'h0, 32'h0, 1'b1, 2'h0};
    rows[7] = {2'h0, 32'hE000_0000, 1'b0, 2'h2, 32'h0, 32'h0, 1'b1, 2'h0};
    rows[8] = {2'h0, 32'h0800_0004, 1'b0, 2'h2, 32'h0, 32'hF000_0001, 1'b0, 2'h0};
    rows[9] = {2'h1, 32'h0800_0FFC, 1'b0, 2'h2, 32'h0, 32'hF000_000F, 1'b0, 2'h2};
    rows[10] = {2'h2, 32'h0800_1000, 1'b0, 2'h2, 32'h0, 32'h0, 1'b1, 2'h0};
    rows[11] = {2'h0, 32'h0000_0004, 1'b0, 2'h2, 32'h0, 32'hF000_0001, 1'b0, 2'h0};
    rows[12] = {2'h1, 32'h1FFF_F7FC, 1'b0, 2'h2, 32'h0, 32'hF000_000F, 1'b0, 2'h0};
    rows[13] = {2'h2, 32'h1FFF_F800, 1'b0, 2'h2, 32'h0, 32'hF000_0000, 1'b0, 2'h0};
    rows[14] = {2'h0, 32'h1FFF_F810, 1'b0, 2'h2, 32'h0, 32'h0, 1'b1, 2'h0};
    rows[15] = {2'h1, 32'h4000_0000, 1'b1, 2'h2, 32'h0, 32'h0, 1'b0, 2'h1};
    rows[16] = {2'h2, 32'h4200_002C, 1'b1, 2'h2, 32'h0000_0001, 32'h0, 1'b0, 2'h3};
    rows[17] = {2'h0, 32'h4000_0000, 1'b0, 2'h2, 32'h0, 32'h0000_0800, 1'b0, 2'h0};
    rows[18] = {2'h1, 32'h6000_0008, 1'b1, 2'h2, 32'hA5A5_0001, 32'h0, 1'b0, 2'h1};
    rows[19] = {2'h2, 32'h6000_0008, 1'b0, 2'h2, 32'h0, 32'hA5A5_0001, 1'b0, 2'h0};
    repeat (8) @(posedge clk);
    chk({31'h0, bv}, 32'h0);
    chk({29'h0, rdy}, 32'h0);
    #1 rstn = 1'b1;
    for (i = 0; i < 20; i = i + 1)
    begin
      r = rows[i];
      dly = r.dly;
      acc(r.m, r.a, r.w, r.sz, r.d);
      chk({31'h0, gerr}, {31'h0, r.ee});
      if (!r.w && !r.ee)
        chk(got, r.e);
    end
    chk({30'h0, mode}, 32'h0);
    p0 = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({30'h0, mode}, 32'h0);
    relatch(1'b1, 1'b0);
    chk({30'h0, mode}, 32'h1);
    acc(2'h0, 32'h0000_0004, 1'b0, 2'h2, 32'h0);
    chk(got, 32'hF000_0001);
    chk(last, 32'h1FFF_F004);
    relatch(1'b1, 1'b1);
    chk({30'h0, mode}, 32'h2);
    acc(2'h1, 32'h0000_0004, 1'b0, 2'h2, 32'h0);
    chk({31'h0, gerr}, 32'h1);
    acc(2'h2, 32'h2000_0010, 1'b0, 2'h2, 32'h0);
    chk(got, 32'hCDCD_AB79);
    serr = 1'b1;
    acc(2'h1, 32'h6000_0008, 1'b0, 2'h2, 32'h0);
    serr = 1'b0;
    chk({31'h0, gerr}, 32'h1);
    report_and_stop;
  end
endmodule // brad_decoder_tb
